// ===== verilog/supply_watchdog_supervisor.sv
// Supervisor: supply reset, watchdog, power-fail flag, supply switch
module supply_watchdog_supervisor #(
   parameter int unsigned STRETCH_TICKS =
      supervisor_pkg::RST_STRETCH_TICKS,
   parameter int unsigned WDOG_TICKS    =
      supervisor_pkg::WDOG_TIMEOUT_TICKS,
   parameter int unsigned TICK_CYC      =
      supervisor_pkg::TICK_DIV_CYC
) (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   input  wire logic main_supply_ok,
   input  wire logic main_below_backup,
   input  wire logic main_above_backup,
   input  wire logic power_fail_sense_in,
   input  wire logic watchdog_strobe_in,
   input  wire logic watchdog_strobe_valid,
   output logic      reset_n,
   output logic      reset_hi,
   output logic      power_fail_flag_n,
   output logic      use_backup_supply
);

   // ****************************************************************
   // Types and state
   // ****************************************************************
   localparam int unsigned CW = supervisor_pkg::TICK_CNT_W;

   typedef struct packed {
      logic [1:0]                 strb_sync;
      logic [1:0]                 vld_sync;
      logic                       strb_last;
      logic                       vld_last;
      supervisor_pkg::rst_state_t rst_st;
      logic [CW-1:0]              stretch_cnt;
      logic [CW-1:0]              wdog_cnt;
      logic                       on_backup;
      logic                       reset_n;
      logic                       reset_hi;
      logic                       pfail_n;
      logic                       use_backup;
   } sup_state_t;

   sup_state_t state_ff;
   sup_state_t nxt_state;
   logic       tick;

   // Saturating count step on a tick
   function automatic logic [CW-1:0] step(input logic [CW-1:0] c,
                                          input logic          en);
      step = (en && c != '1) ? c + 1'h1 : c;
   endfunction

   // ****************************************************************
   // Time base
   // ****************************************************************
   tick_divider #(
      .DIV_CYC (TICK_CYC)
   ) u_tick (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .tick    (tick)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************
   logic strobe_edge;
   logic wdog_enabled;
   logic wdog_expire;
   logic low_hold;

   always_comb begin
      nxt_state = state_ff;

      // Two-stage synchronisers for level and valid flag
      nxt_state.strb_sync = {state_ff.strb_sync[0], watchdog_strobe_in};
      nxt_state.vld_sync  = {state_ff.vld_sync[0],
                             watchdog_strobe_valid};
      nxt_state.strb_last = state_ff.strb_sync[1];
      nxt_state.vld_last  = state_ff.vld_sync[1];

      // Backup switch with hysteresis between the two compares
      if (state_ff.on_backup) begin
         if (main_supply_ok || main_above_backup) begin
            nxt_state.on_backup = 1'h0;
         end
      end else if (!main_supply_ok && main_below_backup) begin
         nxt_state.on_backup = 1'h1;
      end

      // Edge only counts while both samples had a valid level
      strobe_edge = state_ff.vld_sync[1] && state_ff.vld_last &&
                    (state_ff.strb_sync[1] != state_ff.strb_last);
      wdog_enabled = state_ff.vld_sync[1] &&
                     !state_ff.on_backup;
      low_hold = !main_supply_ok || state_ff.on_backup;
      wdog_expire = 1'h0;

      case (state_ff.rst_st)
         supervisor_pkg::ST_HOLD: begin
            nxt_state.stretch_cnt = '0;
            nxt_state.wdog_cnt    = '0;
            if (!low_hold) begin
               nxt_state.rst_st = supervisor_pkg::ST_STRETCH;
            end
         end
         supervisor_pkg::ST_STRETCH: begin
            nxt_state.wdog_cnt    = '0;
            nxt_state.stretch_cnt = step(state_ff.stretch_cnt, tick);
            if (low_hold) begin
               nxt_state.rst_st = supervisor_pkg::ST_HOLD;
            end else if (tick && state_ff.stretch_cnt ==
                         CW'(STRETCH_TICKS - 1)) begin
               nxt_state.rst_st = supervisor_pkg::ST_RUN;
            end
         end
         supervisor_pkg::ST_RUN: begin
            nxt_state.stretch_cnt = '0;
            if (!wdog_enabled || strobe_edge) begin
               nxt_state.wdog_cnt = '0;
            end else begin
               nxt_state.wdog_cnt = step(state_ff.wdog_cnt, tick);
               wdog_expire = tick && state_ff.wdog_cnt ==
                             CW'(WDOG_TICKS - 1);
            end
            if (low_hold) begin
               nxt_state.rst_st = supervisor_pkg::ST_HOLD;
            end else if (wdog_expire) begin
               // Pulse, then count afresh: repeats while stuck
               nxt_state.rst_st = supervisor_pkg::ST_STRETCH;
            end
         end
         default: begin
            nxt_state.rst_st = supervisor_pkg::ST_HOLD;
         end
      endcase

      // Registered outputs, derived from next state
      nxt_state.reset_n  = (nxt_state.rst_st ==
                            supervisor_pkg::ST_RUN);
      nxt_state.reset_hi = !nxt_state.reset_n;
      nxt_state.pfail_n  = power_fail_sense_in &&
                           !nxt_state.on_backup;
      nxt_state.use_backup = nxt_state.on_backup;
   end

   // ****************************************************************
   // State register
   // ****************************************************************
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_ff            <= '0;
         state_ff.rst_st     <= supervisor_pkg::ST_HOLD;
         state_ff.reset_n    <= supervisor_pkg::RST_N_INIT;
         state_ff.reset_hi   <= !supervisor_pkg::RST_N_INIT;
         state_ff.pfail_n    <= supervisor_pkg::PFAIL_N_INIT;
         state_ff.on_backup  <= supervisor_pkg::ON_BACKUP_INIT;
         state_ff.use_backup <= supervisor_pkg::ON_BACKUP_INIT;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign reset_n           = state_ff.reset_n;
   assign reset_hi          = state_ff.reset_hi;
   assign power_fail_flag_n = state_ff.pfail_n;
   assign use_backup_supply = state_ff.use_backup;

endmodule // supply_watchdog_supervisor

// ===== include/supervisor_pkg.sv
// Constants and types for the supply watchdog supervisor
package supervisor_pkg;

   // ****************************************************************
   // Clock and time base
   // ****************************************************************
   localparam int unsigned CLK_HZ          = 20_000_000;
   localparam int unsigned TICK_HZ         = 1_000;
   localparam int unsigned TICK_DIV_CYC    = CLK_HZ / TICK_HZ;
   localparam int unsigned TICK_DIV_W      = 15;

   // ****************************************************************
   // Timeouts, in time-base ticks of 1 ms
   // ****************************************************************
   localparam int unsigned RST_STRETCH_MS  = 200;
   localparam int unsigned RST_STRETCH_MIN_MS = 140;
   localparam int unsigned RST_STRETCH_MAX_MS = 280;
   localparam int unsigned WDOG_TIMEOUT_MS = 1_600;
   localparam int unsigned WDOG_MIN_MS     = 1_000;
   localparam int unsigned WDOG_MAX_MS     = 2_250;
   localparam int unsigned RST_STRETCH_TICKS =
      RST_STRETCH_MS * TICK_HZ / 1_000;
   localparam int unsigned WDOG_TIMEOUT_TICKS =
      WDOG_TIMEOUT_MS * TICK_HZ / 1_000;
   localparam int unsigned TICK_CNT_W      = 12;

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic        RST_N_INIT      = 1'h0;
   localparam logic        PFAIL_N_INIT    = 1'h0;
   localparam logic        ON_BACKUP_INIT  = 1'h0;

   // ****************************************************************
   // Reset sequencer states
   // ****************************************************************
   typedef enum logic [1:0] {
      ST_HOLD    = 2'h0,
      ST_STRETCH = 2'h1,
      ST_RUN     = 2'h3
   } rst_state_t;

endpackage

// ===== verilog/tick_divider.sv
// Divider producing a one-cycle time-base enable pulse
module tick_divider #(
   parameter int unsigned DIV_CYC = supervisor_pkg::TICK_DIV_CYC
) (
   input  wire logic clk_sys,
   input  wire logic rst_b,
   output logic      tick
);

   localparam int unsigned DW = supervisor_pkg::TICK_DIV_W;

   typedef struct packed {
      logic [DW-1:0] cnt;
      logic          tick;
   } div_state_t;

   div_state_t state_ff;
   div_state_t nxt_state;

   always_comb begin
      nxt_state      = state_ff;
      nxt_state.tick = 1'h0;
      if (state_ff.cnt ==
          DW'(DIV_CYC - 1)) begin
         nxt_state.cnt  = '0;
         nxt_state.tick = 1'h1;
      end else begin
         nxt_state.cnt  = state_ff.cnt + 1'h1;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign tick = state_ff.tick;

endmodule // tick_divider

// ===== dv/supervisor_chk.sv
// Port checker for the supply watchdog supervisor
module supervisor_chk #(
   parameter int unsigned STRETCH_TICKS = 5,
   parameter int unsigned WDOG_TICKS    = 10,
   parameter int unsigned TICK_CYC      = 4
) (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic main_supply_ok,
   input wire logic main_below_backup,
   input wire logic main_above_backup,
   input wire logic power_fail_sense_in,
   input wire logic watchdog_strobe_in,
   input wire logic watchdog_strobe_valid,
   input wire logic reset_n,
   input wire logic reset_hi,
   input wire logic power_fail_flag_n,
   input wire logic use_backup_supply
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic [7:0] quiet_ff;
   logic       strobe_ff;
   // Cycles since the strobe pin last moved
   always_ff @(posedge clk_sys) begin
      strobe_ff <= watchdog_strobe_in;
      if (!rst_b || watchdog_strobe_in != strobe_ff) quiet_ff <= 8'h00;
      else if (quiet_ff != 8'hFF) quiet_ff <= quiet_ff + 8'h01;
   end
   property p_cpl; reset_hi == !reset_n; endproperty
   a_cpl: assert property (p_cpl) else $error("reset_hi mismatch");
   property p_low; !main_supply_ok |=> !reset_n; endproperty
   a_low: assert property (p_low) else $error("reset not low");
   property p_pf; !power_fail_sense_in |=> !power_fail_flag_n; endproperty
   a_pf: assert property (p_pf) else $error("flag not low");
   property p_bkr; use_backup_supply |-> !reset_n; endproperty
   a_bkr: assert property (p_bkr) else $error("reset high on backup");
   property p_bkf; use_backup_supply && $past(use_backup_supply)
      |-> !power_fail_flag_n; endproperty
   a_bkf: assert property (p_bkf) else $error("flag on backup");
   property p_in; !main_supply_ok && main_below_backup && !main_above_backup
      |=> use_backup_supply; endproperty
   a_in: assert property (p_in) else $error("no backup switch");
   property p_main; main_supply_ok |=> !use_backup_supply; endproperty
   a_main: assert property (p_main) else $error("backup while ok");
   property p_str; $rose(reset_n)
      |-> !$past(reset_n, (STRETCH_TICKS - 1) * TICK_CYC); endproperty
   a_str: assert property (p_str) else $error("stretch too short");
   property p_flt; (main_supply_ok && !watchdog_strobe_valid) [*6]
      |=> !$fell(reset_n); endproperty
   a_flt: assert property (p_flt) else $error("reset while off");
   property p_wd; $fell(reset_n) && $past(main_supply_ok)
      |-> quiet_ff >= (WDOG_TICKS - 1) * TICK_CYC; endproperty
   a_wd: assert property (p_wd) else $error("early expiry");
endmodule // supervisor_chk

// ===== dv/cpu_model.sv
// Processor model driving the watchdog strobe
module cpu_model (
   input  wire logic       clk_sys,
   input  wire logic       reset_n,
   input  wire logic [1:0] mode,
   output logic            watchdog_strobe_in,
   output logic            watchdog_strobe_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   int   n   = 0;
   logic lvl = 1'h0;
   // Mode 0 fast, 1 slow, 2 stuck, 3 floating
   always @(negedge clk_sys) begin
      n <= n + 1;
      if (mode == 2'h3) lvl <= ~lvl;
      else if (reset_n && mode != 2'h2 && n >= (mode[0] ? 30 : 8)) begin
         lvl <= ~lvl;
         n <= 0;
      end
   end
   assign watchdog_strobe_in = lvl;
   assign watchdog_strobe_valid = (mode != 2'h3);
endmodule // cpu_model

// ===== dv/supply_watchdog_supervisor_bench.sv
// Self-checking bench for the supply watchdog supervisor
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin \
   miscompares++; $display("unexpected %s exp %0h got %0h", nm, e, s); end end
module supply_watchdog_supervisor_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk_sys             = 1'h0;
   logic       rst_b               = 1'h0;
   logic       main_supply_ok      = 1'h1;
   logic       main_below_backup   = 1'h0;
   logic       main_above_backup   = 1'h1;
   logic       power_fail_sense_in = 1'h1;
   logic [1:0] mode                = 2'h0;
   logic       s, reset_n, reset_hi, power_fail_flag_n, use_backup_supply;
   logic       watchdog_strobe_in, watchdog_strobe_valid;
   logic [2:0] prev, exp_v, q[$];
   int         miscompares = 0, checks_done = 0, seed_v;
   wire logic [2:0] obs = {reset_n, power_fail_flag_n, use_backup_supply};
   always #25 clk_sys = ~clk_sys;
   supply_watchdog_supervisor #(.STRETCH_TICKS(5), .WDOG_TICKS(10),
      .TICK_CYC(4)) u_supply_watchdog_supervisor (.clk_sys, .rst_b,
      .main_supply_ok, .main_below_backup, .main_above_backup,
      .power_fail_sense_in, .watchdog_strobe_in, .watchdog_strobe_valid,
      .reset_n, .reset_hi, .power_fail_flag_n, .use_backup_supply);
   cpu_model u_cpu_model (.clk_sys, .reset_n, .mode, .watchdog_strobe_in,
      .watchdog_strobe_valid);
   task automatic step(input int k);
      repeat (k) @(negedge clk_sys);
   endtask
   task automatic wait_rst(input logic v, input int lo, input int hi);
      int n;
      n = 0;
      while (reset_n !== v && n < 200) begin
         @(negedge clk_sys);
         n++;
      end
      `CHK("reset_gap", 1'h1, n >= lo && n <= hi)
   endtask
   task automatic wrap_up();
      $display("checks %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Output watcher: each change must match the oldest note
   always @(negedge clk_sys) begin
      if (!rst_b) prev = obs;
      else begin
         `CHK("reset_hi", ~reset_n, reset_hi)
         if (obs !== prev) begin
            exp_v = q.size() > 0 ? q.pop_front() : 3'h7 ^ obs;
            `CHK("outputs", exp_v, obs)
            prev = obs;
         end
      end
   end
   initial begin
      #600000;
      miscompares++;
      wrap_up();
   end
   initial begin
      seed_v = $urandom(25949);
      q = '{3'h2, 3'h6};
      step(4);
      rst_b = 1'h1;
      wait_rst(1'h1, 17, 26);
      for (int i = 0; i < 9; i++) begin
         s = (i == 8) ? 1'h1 : 1'($urandom());
         if (s != power_fail_sense_in) q.push_back({1'h1, s, 1'h0});
         power_fail_sense_in = s;
         step(3);
      end
      mode = 2'h0;
      step(120);
      mode = 2'h1;
      step(120);
      mode = 2'h3;
      step(120);
      q = {q, 3'h2, 3'h6, 3'h2, 3'h6};
      mode = 2'h2;
      wait_rst(1'h0, 36, 46);
      wait_rst(1'h1, 15, 25);
      wait_rst(1'h0, 36, 46);
      wait_rst(1'h1, 15, 25);
      mode = 2'h0;
      q = {q, 3'h4, 3'h0, 3'h1, 3'h0, 3'h4, 3'h6};
      power_fail_sense_in = 1'h0;
      step(3);
      main_supply_ok = 1'h0;
      step(3);
      main_below_backup = 1'h1;
      main_above_backup = 1'h0;
      step(3);
      power_fail_sense_in = 1'h1;
      step(60);
      main_below_backup = 1'h0;
      step(3);
      `CHK("use_backup", 1'h1, use_backup_supply)
      power_fail_sense_in = 1'h0;
      main_above_backup = 1'h1;
      step(3);
      main_supply_ok = 1'h1;
      wait_rst(1'h1, 17, 26);
      power_fail_sense_in = 1'h1;
      step(3);
      `CHK("queue", 0, q.size())
      wrap_up();
   end
endmodule // supply_watchdog_supervisor_bench
bind supply_watchdog_supervisor supervisor_chk #(.STRETCH_TICKS(STRETCH_TICKS),
   .WDOG_TICKS(WDOG_TICKS), .TICK_CYC(TICK_CYC)) u_supervisor_chk (.clk_sys,
   .rst_b, .main_supply_ok, .main_below_backup, .main_above_backup,
   .power_fail_sense_in, .watchdog_strobe_in, .watchdog_strobe_valid,
   .reset_n, .reset_hi, .power_fail_flag_n, .use_backup_supply);
